/* logic/efr_readout.sv */
// Sample buffer readout: serial slave, tag formation, level interrupt.
// Assumes serial pins from outside the clock domain; sample path on clock.
// How it works
// - 32 entries of 24 bits, own pointers
// - Single read pops at 32nd rising edge
// - Burst pops at edge 32 plus n*24
// - Popped entries are never returned again, save in 111 words read after an overflowed buffer empties
// - Write pointer moved only by samples and clears
// - Irq when unread count reaches threshold 1..32
// - Write into full buffer means overflow
// - Overflow shows in flag and tag
// - Burst 0x20, single 0x21, voltage/tag/tag fields
// - Voltage is 18-bit left-justified two's complement
// - Beat word 0x25: 14 upper bits, zeros
// - Status tag sits in bits 5:3
// - Ordinary valid sample tagged 000
// - Fast recovery sample tagged 001
// - Last valid sample tagged 010
// - Last fast sample tagged 011
// - Empty read tagged 110; 10x unused
// - Overflowed buffer words tagged 111
`timescale 1ns/100ps
`default_nettype none

module efr_readout (
   // Clock and reset
   input wire logic clock,
   input wire logic nrst,
   // Serial pins
   input wire logic sclk,
   input wire logic csb_n,
   input wire logic sdi,
   output logic sdo,
   output logic sdo_oe_n,
   // Internal sample path
   input wire logic sample_valid,
   input wire efr_pkg::efr_sample_t sample,
   input wire logic [efr_pkg::BEAT_W-1:0] beat_interval,
   // Commands, single-cycle pulses
   input wire logic fifo_clear_cmd,
   input wire logic resync_cmd,
   // Configuration and status
   input wire logic [efr_pkg::CNT_W-1:0] buffer_irq_threshold,
   output logic buffer_level_irq,
   output logic buffer_overflow_flag,
   output logic [efr_pkg::CNT_W-1:0] unread_count
);
   import efr_pkg::*;

   typedef enum logic [1:0] {
      EFR_IDLE = 2'b00,
      EFR_CMD = 2'b01,
      EFR_DATA = 2'b10,
      EFR_SKIP = 2'b11
   } efr_state_t;

   // Build the delivered word from an entry and the entries still unread
   function automatic efr_entry_t make_word(input efr_entry_t e,
                                            input logic [CNT_W-1:0] avail,
                                            input logic ovf);
      efr_entry_t w;
      w = e;
      if (ovf) begin
         w.sample_status_tag = TAG_OVF;
      end else if (avail == CNT_ZERO) begin
         w = '0;
         w.sample_status_tag = TAG_EMPTY;
      end else if (avail == CNT_ONE) begin
         w.sample_status_tag = e.sample_status_tag | TAG_EOF;
      end
      return w;
   endfunction

   // Read command aimed at one register
   function automatic logic is_read_of(input logic [7:0] c, input logic [6:0] a);
      return c[0] && (c[7:1] == a);
   endfunction

   // Synchronisers; stage one feeds stage two only
   efr_spi_in_t pin_s1;
   efr_spi_in_t pin_s2;
   logic sclk_s3;
   logic sclk_rise;
   logic selected;

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         pin_s1 <= '{sclk: 1'b0, csb_n: 1'b1, sdi: 1'b0};
         pin_s2 <= '{sclk: 1'b0, csb_n: 1'b1, sdi: 1'b0};
         sclk_s3 <= 1'b0;
      end else begin
         pin_s1 <= '{sclk: sclk, csb_n: csb_n, sdi: sdi};
         pin_s2 <= pin_s1;
         sclk_s3 <= pin_s2.sclk;
      end
   end

   assign sclk_rise = pin_s2.sclk && !sclk_s3;
   assign selected = !pin_s2.csb_n;

   // Sample store
   efr_entry_t head;
   efr_entry_t second;
   efr_entry_t push_entry;
   logic [CNT_W-1:0] count;
   logic overflow;
   logic pop;
   logic clear;

   assign clear = fifo_clear_cmd || resync_cmd;
   always_comb begin
      push_entry.volt = sample.volt;
      push_entry.sample_status_tag = sample.fast ? TAG_FAST : TAG_VALID;
      push_entry.secondary_tag = sample.secondary_tag;
   end

   efr_fifo u_fifo (
      .clock(clock),
      .nrst(nrst),
      .push(sample_valid),
      .push_entry(push_entry),
      .pop(pop),
      .clear(clear),
      .head(head),
      .second(second),
      .count(count),
      .overflow(overflow)
   );

   // Serial transaction state
   efr_state_t state;
   efr_state_t next_state;
   logic [5:0] edge_cnt;
   logic [5:0] next_edge_cnt;
   logic [7:0] cmd;
   logic [7:0] next_cmd;
   logic burst;
   logic next_burst;
   logic from_fifo;
   logic next_from_fifo;
   logic held;
   logic next_held;
   logic [5:0] edge_inc;
   logic [CNT_W-1:0] avail_after;
   // Word loads and shifts requested by the frame logic
   logic load_fifo;
   logic load_beat;
   logic load_next;
   logic shift_bit;
   efr_entry_t next_src;
   logic [CNT_W-1:0] next_avail;
   // Outgoing word
   logic [WORD_W-1:0] shreg;
   logic [WORD_W-1:0] next_shreg;

   assign edge_inc = 6'(edge_cnt + 1'b1);
   assign avail_after = (count == CNT_ZERO) ? CNT_ZERO : CNT_W'(count - 1'b1);
   // A word that went out empty left the head unread: the next word starts there
   assign next_src = held ? second : head;
   assign next_avail = held ? avail_after : count;

   always_comb begin
      next_state = state;
      next_edge_cnt = edge_cnt;
      next_cmd = cmd;
      next_burst = burst;
      next_from_fifo = from_fifo;
      next_held = held;
      pop = 1'b0;
      load_fifo = 1'b0;
      load_beat = 1'b0;
      load_next = 1'b0;
      shift_bit = 1'b0;
      if (!selected) begin
         next_state = EFR_IDLE;
         next_edge_cnt = '0;
         next_held = 1'b0;
      end else begin
         unique case (state)
            EFR_IDLE: begin
               next_state = EFR_CMD;
               next_edge_cnt = '0;
            end
            EFR_CMD: begin
               if (sclk_rise) begin
                  next_cmd = {cmd[6:0], pin_s2.sdi};
                  next_edge_cnt = edge_inc;
                  if (edge_inc == EDGE_CMD) begin
                     next_burst = is_read_of(next_cmd, ADDR_BURST);
                     next_from_fifo = next_burst || is_read_of(next_cmd, ADDR_SINGLE);
                     if (next_from_fifo) begin
                        next_state = EFR_DATA;
                        next_held = (count != CNT_ZERO);
                        load_fifo = 1'b1;
                     end else if (is_read_of(next_cmd, ADDR_BEAT)) begin
                        next_state = EFR_DATA;
                        load_beat = 1'b1;
                     end else begin
                        next_state = EFR_SKIP;
                     end
                  end
               end
            end
            EFR_DATA: begin
               if (sclk_rise) begin
                  next_edge_cnt = edge_inc;
                  shift_bit = 1'b1;
                  if (edge_inc == EDGE_POP) begin
                     // Only an entry that was shipped is marked as read
                     pop = from_fifo && held;
                     if (from_fifo && burst) begin
                        next_edge_cnt = EDGE_RELOAD;
                        next_held = (next_avail != CNT_ZERO);
                        load_next = 1'b1;
                     end else begin
                        next_state = EFR_SKIP;
                     end
                  end
               end
            end
            EFR_SKIP: begin
               next_held = 1'b0;
            end
         endcase
      end
      // A clear empties the store under a word in flight
      if (clear) begin
         next_held = 1'b0;
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         state <= EFR_IDLE;
         edge_cnt <= '0;
         cmd <= 8'h00;
         burst <= 1'b0;
         from_fifo <= 1'b0;
         held <= 1'b0;
      end else begin
         state <= next_state;
         edge_cnt <= next_edge_cnt;
         cmd <= next_cmd;
         burst <= next_burst;
         from_fifo <= next_from_fifo;
         held <= next_held;
      end
   end

   // Outgoing word; the tag is fixed when the word is loaded
   always_comb begin
      next_shreg = shreg;
      if (!selected || state == EFR_SKIP) begin
         next_shreg = '0;
      end else if (load_fifo) begin
         next_shreg = make_word(head, count, overflow);
      end else if (load_beat) begin
         next_shreg = {beat_interval, {BEAT_PAD_W{1'b0}}};
      end else if (load_next) begin
         next_shreg = make_word(next_src, next_avail, overflow);
      end else if (shift_bit) begin
         next_shreg = {shreg[WORD_W-2:0], 1'b0};
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         shreg <= '0;
      end else begin
         shreg <= next_shreg;
      end
   end

   // Outputs
   logic [CNT_W-1:0] thr_eff;
   logic next_irq;
   logic next_sdo;
   logic next_sdo_oe_n;

   always_comb begin
      // A zero threshold behaves as one
      thr_eff = (buffer_irq_threshold == CNT_ZERO) ? CNT_ONE : buffer_irq_threshold;
      next_irq = (count >= thr_eff);
      next_sdo = next_shreg[WORD_W-1];
      next_sdo_oe_n = !selected;
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         buffer_level_irq <= 1'b0;
         buffer_overflow_flag <= 1'b0;
         unread_count <= CNT_ZERO;
         sdo <= 1'b0;
         sdo_oe_n <= 1'b1;
      end else begin
         buffer_level_irq <= next_irq;
         buffer_overflow_flag <= overflow;
         unread_count <= count;
         sdo <= next_sdo;
         sdo_oe_n <= next_sdo_oe_n;
      end
   end

endmodule
`default_nettype wire

/* inc/efr_pkg.sv */
// Constants, layouts and carrier types for the sample buffer readout.
// Assumes one 200 MHz clock domain; serial pins are synchronised inside the readout.
package efr_pkg;

   // Buffer geometry
   localparam int DEPTH = 32;
   localparam int WORD_W = 24;
   localparam int PTR_W = 5;
   localparam int CNT_W = 6;
   localparam int VOLT_W = 18;
   localparam int TAG_W = 3;
   localparam int BEAT_W = 14;
   localparam int BEAT_PAD_W = WORD_W - BEAT_W;
   localparam logic [CNT_W-1:0] CNT_FULL = 6'h20;
   localparam logic [CNT_W-1:0] CNT_ONE = 6'h01;
   localparam logic [CNT_W-1:0] CNT_ZERO = 6'h00;

   // Register addresses (7-bit)
   localparam logic [6:0] ADDR_BURST = 7'h20;
   localparam logic [6:0] ADDR_SINGLE = 7'h21;
   localparam logic [6:0] ADDR_BEAT = 7'h25;

   // Serial clock rising edge counts
   localparam logic [5:0] EDGE_CMD = 6'h08;
   localparam logic [5:0] EDGE_POP = 6'h20;
   localparam logic [5:0] BURST_WORD_EDGES = 6'h18;
   localparam logic [5:0] EDGE_RELOAD = EDGE_POP - BURST_WORD_EDGES;

   // Sample status tag codes
   localparam logic [TAG_W-1:0] TAG_VALID = 3'h0;
   localparam logic [TAG_W-1:0] TAG_FAST = 3'h1;
   localparam logic [TAG_W-1:0] TAG_EOF = 3'h2;
   localparam logic [TAG_W-1:0] TAG_EMPTY = 3'h6;
   localparam logic [TAG_W-1:0] TAG_OVF = 3'h7;

   // Stored and delivered word: voltage [23:6], status tag [5:3], secondary tag [2:0]
   typedef struct packed {
      logic [VOLT_W-1:0] volt;
      logic [TAG_W-1:0] sample_status_tag;
      logic [TAG_W-1:0] secondary_tag;
   } efr_entry_t;

   // Sample from the internal conversion path
   typedef struct packed {
      logic [VOLT_W-1:0] volt;
      logic fast;
      logic [TAG_W-1:0] secondary_tag;
   } efr_sample_t;

   // Serial input pins
   typedef struct packed {
      logic sclk;
      logic csb_n;
      logic sdi;
   } efr_spi_in_t;

endpackage

/* logic/efr_fifo.sv */
// Circular 32 x 24 sample store with read and write pointers.
// Assumes push, pop and clear are single-cycle pulses on the same clock.
`timescale 1ns/100ps
`default_nettype none

module efr_fifo (
   // Clock and reset
   input wire logic clock,
   input wire logic nrst,
   // Write side, internal sample path
   input wire logic push,
   input wire efr_pkg::efr_entry_t push_entry,
   // Read side
   input wire logic pop,
   input wire logic clear,
   output efr_pkg::efr_entry_t head,
   output efr_pkg::efr_entry_t second,
   output logic [efr_pkg::CNT_W-1:0] count,
   output logic overflow
);
   import efr_pkg::*;

   efr_entry_t mem [DEPTH];
   logic [PTR_W-1:0] rd_ptr;
   logic [PTR_W-1:0] wr_ptr;
   logic [PTR_W-1:0] next_rd_ptr;
   logic [PTR_W-1:0] next_wr_ptr;
   logic [CNT_W-1:0] next_count;
   logic next_overflow;
   logic do_push;
   logic do_pop;
   logic full;

   assign full = (count == CNT_FULL);
   assign head = mem[rd_ptr];
   assign second = mem[PTR_W'(rd_ptr + 1'b1)];

   always_comb begin
      do_pop = pop && (count != CNT_ZERO) && !clear;
      do_push = push && (!full || do_pop) && !clear;
      next_rd_ptr = rd_ptr;
      next_wr_ptr = wr_ptr;
      next_count = count;
      // Overflow set wins over a clear in the same cycle
      next_overflow = (push && full && !do_pop) || (overflow && !clear);
      if (clear) begin
         next_rd_ptr = '0;
         next_wr_ptr = '0;
         next_count = CNT_ZERO;
      end else begin
         if (do_pop) begin
            next_rd_ptr = PTR_W'(rd_ptr + 1'b1);
         end
         if (do_push) begin
            next_wr_ptr = PTR_W'(wr_ptr + 1'b1);
         end
         next_count = CNT_W'(count + {5'h00, do_push} - {5'h00, do_pop});
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         rd_ptr <= '0;
         wr_ptr <= '0;
         count <= CNT_ZERO;
         overflow <= 1'b0;
      end else begin
         rd_ptr <= next_rd_ptr;
         wr_ptr <= next_wr_ptr;
         count <= next_count;
         overflow <= next_overflow;
      end
   end

   // Storage is written in place; contents need no reset
   always_ff @(posedge clock) begin
      if (do_push) begin
         mem[wr_ptr] <= push_entry;
      end
   end

endmodule
`default_nettype wire

/* test/efr_readout_assertions.sv */
// Port-level checks for the sample buffer readout.
// Bound into efr_readout; one clock domain, async active-low reset.
`timescale 1ns/100ps
`default_nettype none
module efr_readout_assertions
   import efr_pkg::*;
(
   // Clock and reset
   input wire logic clock,
   input wire logic nrst,
   // Watched ports
   input wire logic sclk,
   input wire logic csb_n,
   input wire logic sample_valid,
   input wire logic fifo_clear_cmd,
   input wire logic resync_cmd,
   input wire logic [efr_pkg::CNT_W-1:0] buffer_irq_threshold,
   input wire logic buffer_level_irq,
   input wire logic buffer_overflow_flag,
   input wire logic [efr_pkg::CNT_W-1:0] unread_count,
   input wire logic sdo_oe_n
);
   logic clr;
   logic [2:0] sck_q;
   logic [2:0] clr_q;
   logic [6:0] rises;
   logic pop_ok;
   assign clr = fifo_clear_cmd | resync_cmd;
   assign pop_ok = rises >= 7'h20 && (rises - 7'h20) % 7'h18 == 7'h00;
   // Own count of serial clock rises in the frame
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         sck_q <= 3'h0;
         clr_q <= 3'h0;
         rises <= 7'h00;
      end else begin
         sck_q <= {sck_q[1:0], sclk};
         clr_q <= {clr_q[1:0], clr};
         rises <= csb_n ? 7'h00 : rises + 7'(sck_q[1] & ~sck_q[2]);
      end
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);
   sequence s_clr; clr ##1 !sample_valid [*3]; endsequence
   sequence s_empty; unread_count == CNT_ZERO && !buffer_overflow_flag; endsequence
   property p_depth; unread_count <= CNT_FULL; endproperty
   a_depth: assert property (p_depth) else $error("count above depth");
   property p_pop; $past(unread_count) - unread_count == CNT_ONE && clr_q == 3'h0
      |-> pop_ok; endproperty
   a_pop: assert property (p_pop) else $error("pop off edge");
   property p_grow; unread_count > $past(unread_count)
      |-> $past(sample_valid, 2) || $past(sample_valid, 3); endproperty
   a_grow: assert property (p_grow) else $error("growth without sample");
   property p_irq_on; unread_count >= $past(buffer_irq_threshold) |-> buffer_level_irq;
   endproperty
   a_irq_on: assert property (p_irq_on) else $error("irq missing");
   property p_irq_off; unread_count < $past(buffer_irq_threshold) |-> !buffer_level_irq;
   endproperty
   a_irq_off: assert property (p_irq_off) else $error("irq stuck");
   property p_oe_off; csb_n [*4] |-> sdo_oe_n; endproperty
   a_oe_off: assert property (p_oe_off) else $error("data line driven while idle");
   property p_oe_on; !csb_n [*4] |-> !sdo_oe_n; endproperty
   a_oe_on: assert property (p_oe_on) else $error("data line not driven");
   property p_ovf; sample_valid && csb_n && unread_count == CNT_FULL && clr_q == 3'h0 && !clr
      |-> ##[1:3] buffer_overflow_flag; endproperty
   a_ovf: assert property (p_ovf) else $error("overflow missed");
   property p_ovf_hold; buffer_overflow_flag && !clr && clr_q == 3'h0 |=> buffer_overflow_flag;
   endproperty
   a_ovf_hold: assert property (p_ovf_hold) else $error("overflow lost");
   property p_clear; s_clr |-> s_empty; endproperty
   a_clear: assert property (p_clear) else $error("clear failed");
endmodule
bind efr_readout efr_readout_assertions u_chk (
   .clock, .nrst, .sclk, .csb_n, .sample_valid, .fifo_clear_cmd, .resync_cmd,
   .buffer_irq_threshold, .buffer_level_irq, .buffer_overflow_flag, .unread_count, .sdo_oe_n
);
`default_nettype wire

/* test/efr_host_model.sv */
// Serial host model: mode 0 master reading buffer words.
// Needs the device clock; pins move on its falling edges.
`timescale 1ns/100ps
`default_nettype none
module efr_host_model (
   // Clock
   input wire logic clock,
   // Serial pins
   output logic sclk,
   output logic csb_n,
   output logic sdi,
   input wire logic sdo
);
   initial begin
      sclk = 1'b0;
      csb_n = 1'b1;
      sdi = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(negedge clock);
   endtask
   // Command byte, then nw words into rx; half period of 16 clocks
   task automatic xfer(input logic [7:0] cmd, input int nw, output logic [95:0] rx);
      rx = '0;
      tick(1);
      csb_n = 1'b0;
      tick(4);
      for (int i = 0; i < 8 + 24 * nw; i++) begin
         sdi = i < 8 ? cmd[7 - i] : 1'b0;
         tick(16);
         sclk = 1'b1;
         rx = i < 8 ? rx : {rx[94:0], sdo};
         tick(16);
         sclk = 1'b0;
      end
      tick(4);
      csb_n = 1'b1;
      // Released data line shows the inverse of its last value
      sdi = ~sdi;
      tick(8);
   endtask
endmodule
`default_nettype wire

/* test/testbench.sv */
// Self-checking bench for the sample buffer readout.
// Inputs move on falling clock edges; the host model runs the link.
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import efr_pkg::*;
   logic clock = 1'b0;
   logic nrst = 1'b0;
   logic sclk, csb_n, sdi, sdo, sdo_oe_n, buffer_level_irq, buffer_overflow_flag;
   logic sample_valid = 1'b0;
   efr_sample_t sample = '0;
   logic [BEAT_W-1:0] beat_interval = 14'h2A5C;
   logic fifo_clear_cmd = 1'b0;
   logic resync_cmd = 1'b0;
   logic [CNT_W-1:0] buffer_irq_threshold = 6'h03;
   logic [CNT_W-1:0] unread_count;
   logic [95:0] rx;
   int bad_count = 0;
   int comparisons = 0;
   int cycles = 0;
   always #2.5 clock = ~clock;
   efr_readout dut (
      .clock, .nrst, .sclk, .csb_n, .sdi, .sdo, .sdo_oe_n, .sample_valid, .sample,
      .beat_interval, .fifo_clear_cmd, .resync_cmd, .buffer_irq_threshold,
      .buffer_level_irq, .buffer_overflow_flag, .unread_count
   );
   efr_host_model host (.clock, .sclk, .csb_n, .sdi, .sdo);
   task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %0s expected %h seen %h", what, exp, got);
      end
   endtask
   // Count, interrupt and overflow flag side by side
   task automatic st(input logic [7:0] exp);
      chk("status", {16'h0, exp}, {16'h0, unread_count, buffer_level_irq, buffer_overflow_flag});
   endtask
   task automatic push(input logic [17:0] v, input logic f, input logic [2:0] p);
      @(negedge clock);
      sample_valid = 1'b1;
      sample = {v, f, p};
      @(negedge clock);
      sample_valid = 1'b0;
      repeat (4) @(negedge clock);
   endtask
   task automatic rd(input logic [6:0] a, input int n);
      host.xfer({a, 1'b1}, n, rx);
   endtask
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   always @(posedge clock) begin
      cycles++;
      if (cycles == 30000) begin
         bad_count++;
         final_report();
      end
   end
   initial begin
      repeat (5) @(negedge clock);
      nrst = 1'b1;
      repeat (2) @(negedge clock);
      chk("released", 24'h000001, {23'h0, sdo_oe_n});
      rd(ADDR_SINGLE, 1);
      chk("empty", {18'h0, TAG_EMPTY, 3'h0}, rx[23:0]);
      rd(ADDR_BEAT, 1);
      chk("beat", {beat_interval, 10'h000}, rx[23:0]);
      $display("test empty and beat done");
      push(18'h20001, 1'b0, 3'h5);
      push(18'h1FFFE, 1'b1, 3'h2);
      st(8'h08);
      push(18'h00ABC, 1'b1, 3'h7);
      st(8'h0E);
      rd(ADDR_SINGLE, 1);
      chk("valid", {18'h20001, TAG_VALID, 3'h5}, rx[23:0]);
      st(8'h08);
      rd(ADDR_BURST, 3);
      chk("fast", {18'h1FFFE, TAG_FAST, 3'h2}, rx[71:48]);
      chk("fast last", {18'h00ABC, TAG_FAST | TAG_EOF, 3'h7}, rx[47:24]);
      chk("after end", {18'h0, TAG_EMPTY, 3'h0}, rx[23:0]);
      st(8'h00);
      push(18'h3FFFF, 1'b0, 3'h1);
      rd(ADDR_SINGLE, 1);
      chk("valid last", {18'h3FFFF, TAG_EOF, 3'h1}, rx[23:0]);
      // A sample that lands under an empty word must stay unread
      fork
         rd(ADDR_SINGLE, 1);
         begin
            repeat (300) @(negedge clock);
            push(18'h15555, 1'b0, 3'h3);
         end
      join
      chk("late empty", {18'h0, TAG_EMPTY, 3'h0}, rx[23:0]);
      st(8'h04);
      rd(ADDR_SINGLE, 1);
      chk("late sample", {18'h15555, TAG_EOF, 3'h3}, rx[23:0]);
      $display("test tags done");
      buffer_irq_threshold = 6'h20;
      for (int k = 0; k < 2; k++) begin
         for (int n = 0; n < 32; n++) begin
            push(18'h01000 + 18'(n), 1'b0, 3'h0);
         end
         st(8'h82);
         push(18'h02000, 1'b0, 3'h0);
         st(8'h83);
         rd(ADDR_SINGLE, 1);
         chk("overflow", {18'h01000, TAG_OVF, 3'h0}, rx[23:0]);
         st(8'h7D);
         @(negedge clock);
         {fifo_clear_cmd, resync_cmd} = k ? 2'b01 : 2'b10;
         @(negedge clock);
         {fifo_clear_cmd, resync_cmd} = 2'b00;
         repeat (4) @(negedge clock);
         st(8'h00);
      end
      $display("test overflow done");
      final_report();
   end
endmodule
`default_nettype wire
